/* File: logic/uhi_pkg.sv */
// Constants, types and field layouts of the handshake interrupt output block
package uhi_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_CFG   = 8'h10;
  localparam logic [7:0] ADDR_MASK  = 8'h18;
  localparam logic [7:0] ADDR_STAT  = 8'h1C;
  localparam logic [7:0] ADDR_GEN   = 8'h20;

  // ==========================================================================
  // Field values and reset values
  localparam logic [1:0] FLT_ALL    = 2'h0;
  localparam logic [1:0] FLT_ACK    = 2'h1;
  localparam logic [1:0] FLT_RESET  = 2'h3;
  localparam int         FLT_FIRST  = 1;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;

  // Status and mask bit positions
  localparam int         NUM_SRC    = 3;
  localparam int         SRC_CTRL   = 0;
  localparam int         SRC_IN     = 1;
  localparam int         SRC_OUT    = 2;
  localparam int         NUM_EP     = 8;

  // ==========================================================================
  // Pulse timing
  localparam int         PULSE_NS   = 60;
  localparam int         CLK_NS     = 20;
  localparam int         PULSE_CYC  = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int         CNT_W      = 3;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_NYET, HS_NONE} uhi_hs_kind_e;
  typedef enum logic [1:0] {TOK_SETUP, TOK_IN, TOK_OUT, TOK_OTHER} uhi_token_e;

  typedef struct packed {
    logic [1:0] ctrl_ep_irq_filter;
    logic [1:0] in_ep_irq_filter;
    logic [1:0] out_ep_irq_filter;
    logic       irq_pulse_select;
    logic       irq_active_high;
  } uhi_cfg_s;

  typedef struct packed {
    logic         valid;
    uhi_token_e   token;
    uhi_hs_kind_e kind;
    logic [2:0]   ep;
  } uhi_hs_s;

  localparam uhi_cfg_s CFG_RESET = '{FLT_RESET, FLT_RESET, FLT_RESET, 1'b0, 1'b0};

endpackage : uhi_pkg

/* File: logic/uhi_pulse_gen.sv */
// Fixed-width pulse generator for the pulsed interrupt mode
`timescale 1ns/10ps
module uhi_pulse_gen (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic trigger,
  output logic      busy
);

  typedef enum logic {PG_IDLE, PG_ACTIVE} uhi_pg_state_e;

  localparam logic [uhi_pkg::CNT_W-1:0] CNT_LOAD = uhi_pkg::CNT_W'(uhi_pkg::PULSE_CYC - 1);
  localparam logic [uhi_pkg::CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [uhi_pkg::CNT_W-1:0] CNT_ONE  = 3'h1;

  uhi_pg_state_e                 state_r;
  logic [uhi_pkg::CNT_W-1:0]     cnt_r;

  // ==========================================================================
  // Pulse state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PG_IDLE;
      cnt_r   <= CNT_ZERO;
    end else begin
      case (state_r)
        PG_IDLE: begin
          if (trigger) begin
            state_r <= PG_ACTIVE;
            cnt_r   <= CNT_LOAD;
          end
        end
        PG_ACTIVE: begin
          if (cnt_r == CNT_ZERO) begin
            state_r <= PG_IDLE;
          end else begin
            cnt_r <= cnt_r - CNT_ONE;
          end
        end
        default: begin
          state_r <= PG_IDLE;
          cnt_r   <= CNT_ZERO;
        end
      endcase
    end
  end

  assign busy = (state_r == PG_ACTIVE);

endmodule : uhi_pulse_gen

/* File: logic/uhi_irq_ctrl.sv */
// Handshake interrupt output controller with register port
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
module uhi_irq_ctrl (
  input  wire logic            sys_clk,
  input  wire logic            rst_n,
  input  wire uhi_pkg::uhi_hs_s hs_evt,
  input  wire logic            usb_bus_reset,
  input  wire logic [7:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic [7:0]           reg_rdata,
  output logic                 int_pin
);

  // ==========================================================================
  // Declarations
  uhi_pkg::uhi_cfg_s                 cfg_r;
  logic [uhi_pkg::NUM_SRC-1:0]       mask_r;
  logic [uhi_pkg::NUM_SRC-1:0]       stat_r;
  logic                              irq_global_enable_r;
  logic [uhi_pkg::NUM_EP-1:0]        armed_r;
  logic [7:0]                        rdata_r;
  logic                              int_pin_r;

  logic [uhi_pkg::NUM_SRC-1:0]       evt_vec;
  logic [uhi_pkg::NUM_SRC-1:0]       stat_clr;
  logic                              is_ack;
  logic                              is_nak;
  logic                              is_nyet;
  logic                              first_nak;
  logic                              ep_zero;
  logic                              pending;
  logic                              pulse_trig;
  logic                              pulse_busy;
  logic                              asserted;
  logic                              wr_cfg;
  logic                              wr_mask;
  logic                              wr_gen;
  logic                              rd_stat;

  // ==========================================================================
  // Handshake decode
  assign is_ack    = hs_evt.valid && (hs_evt.kind == uhi_pkg::HS_ACK);
  assign is_nak    = hs_evt.valid && (hs_evt.kind == uhi_pkg::HS_NAK);
  assign is_nyet   = hs_evt.valid && (hs_evt.kind == uhi_pkg::HS_NYET);
  assign ep_zero   = (hs_evt.ep == 3'h0);
  assign first_nak = is_nak && armed_r[hs_evt.ep];

  // Filter decision per field value
  function automatic logic flt_pass(
    input logic [1:0] flt,
    input logic       ack,
    input logic       nak,
    input logic       nyet,
    input logic       first,
    input logic       nyet_ok
  );
    logic nak_ok;
    nak_ok = (flt == uhi_pkg::FLT_ALL) || (flt[uhi_pkg::FLT_FIRST] && first);
    flt_pass = ack || (nyet && nyet_ok) || (nak && nak_ok);
  endfunction : flt_pass

  // ==========================================================================
  // Event sources
  always_comb begin
    evt_vec = '0;
    if (ep_zero) begin
      evt_vec[uhi_pkg::SRC_CTRL] = flt_pass(cfg_r.ctrl_ep_irq_filter, is_ack, is_nak,
                                            1'b0, first_nak, 1'b0);
    end else if (hs_evt.token == uhi_pkg::TOK_IN) begin
      evt_vec[uhi_pkg::SRC_IN] = flt_pass(cfg_r.in_ep_irq_filter, is_ack, is_nak,
                                          1'b0, first_nak, 1'b0);
    end else if (hs_evt.token == uhi_pkg::TOK_OUT) begin
      evt_vec[uhi_pkg::SRC_OUT] = flt_pass(cfg_r.out_ep_irq_filter, is_ack, is_nak,
                                           is_nyet, first_nak, 1'b1);
    end
  end

  // ==========================================================================
  // First NAK tracking per endpoint
  genvar g;
  generate
    for (g = 0; g < uhi_pkg::NUM_EP; g++) begin : g_arm
      logic hit;
      assign hit = hs_evt.valid && (hs_evt.ep == 3'(g));
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          armed_r[g] <= 1'b0;
        end else if (usb_bus_reset) begin
          armed_r[g] <= 1'b0;
        end else if (hit && is_ack && (hs_evt.token == uhi_pkg::TOK_SETUP)) begin
          armed_r[g] <= 1'b1;
        end else if (hit && is_nak) begin
          armed_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Register port decode
  assign wr_cfg  = reg_wr && (reg_addr == uhi_pkg::ADDR_CFG);
  assign wr_mask = reg_wr && (reg_addr == uhi_pkg::ADDR_MASK);
  assign wr_gen  = reg_wr && (reg_addr == uhi_pkg::ADDR_GEN);
  assign rd_stat = reg_rd && (reg_addr == uhi_pkg::ADDR_STAT);

  // Configuration register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= uhi_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      cfg_r <= uhi_pkg::uhi_cfg_s'(reg_wdata);
    end else if (usb_bus_reset) begin
      cfg_r.ctrl_ep_irq_filter <= uhi_pkg::FLT_RESET;
      cfg_r.in_ep_irq_filter   <= uhi_pkg::FLT_RESET;
      cfg_r.out_ep_irq_filter  <= uhi_pkg::FLT_RESET;
    end
  end

  // Mask register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= '0;
    end else if (wr_mask) begin
      mask_r <= reg_wdata[uhi_pkg::NUM_SRC-1:0];
    end
  end

  // Global enable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_global_enable_r <= 1'b0;
    end else if (wr_gen) begin
      irq_global_enable_r <= reg_wdata[0];
    end
  end

  // Sticky status, cleared by a read; a new event wins over the clear
  assign stat_clr = rd_stat ? stat_r : '0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= '0;
    end else begin
      stat_r <= (stat_r & ~stat_clr) | evt_vec;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= uhi_pkg::BYTE_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        uhi_pkg::ADDR_CFG:  rdata_r <= cfg_r;
        uhi_pkg::ADDR_MASK: rdata_r <= {5'h00, mask_r};
        uhi_pkg::ADDR_STAT: rdata_r <= {5'h00, stat_r};
        uhi_pkg::ADDR_GEN:  rdata_r <= {7'h00, irq_global_enable_r};
        default:            rdata_r <= uhi_pkg::BYTE_ZERO;
      endcase
    end else begin
      rdata_r <= uhi_pkg::BYTE_ZERO;
    end
  end

  assign reg_rdata = rdata_r;

  // ==========================================================================
  // Interrupt output
  assign pending    = irq_global_enable_r && |(stat_r & mask_r);
  assign pulse_trig = irq_global_enable_r && cfg_r.irq_pulse_select
                      && |(evt_vec & mask_r);

  uhi_pulse_gen u_pulse (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .trigger (pulse_trig),
    .busy    (pulse_busy)
  );

  assign asserted = cfg_r.irq_pulse_select ? pulse_busy : pending;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_pin_r <= 1'b1;
    end else begin
      int_pin_r <= cfg_r.irq_active_high ? asserted : !asserted;
    end
  end

  assign int_pin = int_pin_r;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_pulse_start;
    pulse_trig && !pulse_busy;
  endsequence

  sequence s_pulse_body;
    pulse_busy [*3] ##1 !pulse_busy;
  endsequence

  sequence s_pin_pulse;
    (int_pin == cfg_r.irq_active_high) [*3];
  endsequence

  sequence s_setup_ack;
    is_ack && (hs_evt.token == uhi_pkg::TOK_SETUP) && !usb_bus_reset;
  endsequence

  sequence s_stat_read;
    rd_stat && (evt_vec == '0);
  endsequence

  chk_ep0_ack_event: assert property (
    (hs_evt.valid && hs_evt.kind == uhi_pkg::HS_ACK && hs_evt.ep == 3'h0)
      |=> stat_r[uhi_pkg::SRC_CTRL])
    else $error("ep0 ACK did not set the control status bit");

  chk_cfg_readback: assert property (
    (wr_cfg ##1 (reg_rd && reg_addr == uhi_pkg::ADDR_CFG && !reg_wr && !usb_bus_reset))
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("configuration byte did not read back as written");

  chk_ctrl_ack_only: assert property (
    (cfg_r.ctrl_ep_irq_filter == uhi_pkg::FLT_ACK && is_nak && ep_zero)
      |-> !evt_vec[uhi_pkg::SRC_CTRL])
    else $error("control NAK raised an event with ACK-only filter");

  chk_in_all_nak: assert property (
    (cfg_r.in_ep_irq_filter == uhi_pkg::FLT_ALL && is_nak && !ep_zero
      && hs_evt.token == uhi_pkg::TOK_IN) |=> stat_r[uhi_pkg::SRC_IN])
    else $error("IN NAK missed with all-handshake filter");

  chk_out_nyet: assert property (
    (is_nyet && !ep_zero && hs_evt.token == uhi_pkg::TOK_OUT)
      |=> stat_r[uhi_pkg::SRC_OUT])
    else $error("OUT NYET did not raise an event");

  chk_first_nak_once: assert property (
    (is_nak && !usb_bus_reset) |=> !armed_r[$past(hs_evt.ep)])
    else $error("first NAK tracker not cleared by a NAK");

  chk_level_idle_pol: assert property (
    (!cfg_r.irq_pulse_select && !pending)
      |=> int_pin == !$past(cfg_r.irq_active_high))
    else $error("idle level does not follow the polarity bit");

  chk_pulse_width: assert property (
    s_pulse_start |=> s_pulse_body)
    else $error("pulse not exactly three cycles long");

  chk_pulse_edge: assert property (
    (s_pulse_start ##1 (pulse_busy && $stable(cfg_r.irq_active_high)))
      |=> s_pin_pulse)
    else $error("pulse level does not match polarity");

  chk_bus_reset_cfg: assert property (
    (usb_bus_reset && !wr_cfg) |=> (cfg_r[7:2] == 6'h3F)
      && (cfg_r[1:0] == $past(cfg_r[1:0])))
    else $error("bus reset handled configuration wrongly");

  chk_level_enable: assert property (
    (!cfg_r.irq_pulse_select && pending)
      |=> int_pin == $past(cfg_r.irq_active_high))
    else $error("pending unmasked event not shown on level output");

  chk_no_stale_pulse: assert property (
    (!irq_global_enable_r && !pulse_busy) |=> !pulse_busy)
    else $error("pulse started while globally disabled");

  chk_no_restart: assert property (
    (pulse_busy && pulse_trig) |-> ##[1:3] !pulse_busy)
    else $error("pulse restarted while in progress");

  chk_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == uhi_pkg::BYTE_ZERO)
    else $error("read data not zero outside a read");

  chk_rdata_stat: assert property (
    rd_stat |=> reg_rdata[uhi_pkg::NUM_SRC-1:0] == $past(stat_r))
    else $error("status read returned wrong bits");

  chk_stat_read_clr: assert property (
    s_stat_read |=> stat_r == '0)
    else $error("status read did not clear the bits");

  chk_stat_sticky: assert property (
    (stat_r[uhi_pkg::SRC_CTRL] && !rd_stat) |=> stat_r[uhi_pkg::SRC_CTRL])
    else $error("status bit lost without a read");

  chk_ep0_nak_all: assert property (
    (cfg_r.ctrl_ep_irq_filter == uhi_pkg::FLT_ALL && is_nak && ep_zero)
      |=> stat_r[uhi_pkg::SRC_CTRL])
    else $error("control NAK missed with all-handshake filter");

  chk_first_nak_evt: assert property (
    (first_nak && ep_zero && cfg_r.ctrl_ep_irq_filter[uhi_pkg::FLT_FIRST])
      |=> stat_r[uhi_pkg::SRC_CTRL])
    else $error("first control NAK did not raise an event");

  chk_in_ack_only: assert property (
    (cfg_r.in_ep_irq_filter == uhi_pkg::FLT_ACK && is_nak && !ep_zero
      && hs_evt.token == uhi_pkg::TOK_IN) |-> !evt_vec[uhi_pkg::SRC_IN])
    else $error("IN NAK raised an event with ACK-only filter");

  chk_data_setup_skip: assert property (
    (hs_evt.valid && !ep_zero && hs_evt.token == uhi_pkg::TOK_SETUP)
      |-> evt_vec == '0)
    else $error("setup handshake on a data endpoint raised an event");

  chk_out_ack_only: assert property (
    (cfg_r.out_ep_irq_filter == uhi_pkg::FLT_ACK && is_nak && !ep_zero
      && hs_evt.token == uhi_pkg::TOK_OUT) |-> !evt_vec[uhi_pkg::SRC_OUT])
    else $error("OUT NAK raised an event with ACK-only filter");

  chk_nyet_ignored: assert property (
    (is_nyet && (ep_zero || hs_evt.token == uhi_pkg::TOK_IN)) |-> evt_vec == '0)
    else $error("NYET outside data OUT raised an event");

  chk_setup_arms: assert property (
    s_setup_ack |=> armed_r[$past(hs_evt.ep)])
    else $error("setup ACK did not arm first NAK");

  chk_later_nak: assert property (
    (is_nak && !first_nak && ep_zero && cfg_r.ctrl_ep_irq_filter[uhi_pkg::FLT_FIRST])
      |-> !evt_vec[uhi_pkg::SRC_CTRL])
    else $error("later control NAK raised an event");

  chk_bus_reset_arm: assert property (
    usb_bus_reset |=> armed_r == '0)
    else $error("bus reset left a first NAK armed");

  chk_pulse_idle: assert property (
    (cfg_r.irq_pulse_select && !pulse_busy)
      |=> int_pin == !$past(cfg_r.irq_active_high))
    else $error("pulse output not idle between pulses");

  chk_disabled_level: assert property (
    (!cfg_r.irq_pulse_select && !irq_global_enable_r)
      |=> int_pin == !$past(cfg_r.irq_active_high))
    else $error("level output active while globally disabled");

  chk_mask_block: assert property (
    (!cfg_r.irq_pulse_select && (stat_r & mask_r) == '0)
      |=> int_pin == !$past(cfg_r.irq_active_high))
    else $error("masked status drove the level output");

endmodule : uhi_irq_ctrl

/* File: testbench/uhi_host_model.sv */
// Processor-side model that watches the interrupt pin
`timescale 1ns/10ps
module uhi_host_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       int_pin,
  input  wire logic       active_high,
  output logic [7:0]      edge_cnt
);
  logic seen_r;

  // ==========================================================================
  // Input sense follows the programmed polarity; counts leading edges
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_r   <= 1'b0;
      edge_cnt <= 8'h00;
    end else begin
      seen_r <= (int_pin === active_high);
      if ((int_pin === active_high) && !seen_r) begin
        edge_cnt <= edge_cnt + 8'h01;
      end
    end
  end
endmodule : uhi_host_model

/* File: testbench/uhi_irq_ctrl_test.sv */
// Self-checking bench of the handshake interrupt output controller
`timescale 1ns/10ps
module uhi_irq_ctrl_test;
  localparam uhi_pkg::uhi_token_e   T_SET = uhi_pkg::TOK_SETUP;
  localparam uhi_pkg::uhi_token_e   T_IN  = uhi_pkg::TOK_IN;
  localparam uhi_pkg::uhi_token_e   T_OUT = uhi_pkg::TOK_OUT;
  localparam uhi_pkg::uhi_hs_kind_e K_ACK = uhi_pkg::HS_ACK;
  localparam uhi_pkg::uhi_hs_kind_e K_NAK = uhi_pkg::HS_NAK;
  localparam uhi_pkg::uhi_hs_kind_e K_NYT = uhi_pkg::HS_NYET;
  logic             sys_clk;
  logic             rst_n;
  uhi_pkg::uhi_hs_s hs_evt;
  logic             usb_bus_reset;
  logic [7:0]       reg_addr;
  logic [7:0]       reg_wdata;
  logic             reg_wr;
  logic             reg_rd;
  logic [7:0]       reg_rdata;
  logic             int_pin;
  logic             host_high;
  logic [7:0]       host_edges;
  logic [7:0]       rv;
  logic [7:0]       e0;
  int               num_errors;
  int               samples_checked;

  // ==========================================================================
  // Instances and clock
  uhi_irq_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .hs_evt(hs_evt),
    .usb_bus_reset(usb_bus_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .int_pin(int_pin));
  uhi_host_model host (.sys_clk(sys_clk), .rst_n(rst_n), .int_pin(int_pin),
    .active_high(host_high), .edge_cnt(host_edges));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ==========================================================================
  // Bus, event and compare tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) reg_addr <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk) reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic wrd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk) reg_addr <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk) reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : wrd

  task automatic ev(input uhi_pkg::uhi_token_e t, input uhi_pkg::uhi_hs_kind_e k,
                    input logic [2:0] ep);
    @(posedge sys_clk) hs_evt <= '{1'b1, t, k, ep};
    @(posedge sys_clk) hs_evt.valid <= 1'b0;
  endtask : ev

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic act(input logic hi, output logic [7:0] n);
    n = 8'h00;
    repeat (10) begin
      #1;
      if (int_pin === hi) n = n + 8'h01;
      @(posedge sys_clk);
    end
    #1;
  endtask : act

  task automatic fchk(input logic [7:0] c, input uhi_pkg::uhi_token_e t,
                      input uhi_pkg::uhi_hs_kind_e k, input logic [2:0] ep,
                      input logic [7:0] exp);
    wr(uhi_pkg::ADDR_CFG, c);
    ev(t, k, ep);
    cyc(1);
    rd(uhi_pkg::ADDR_STAT, rv);
    chk(rv, exp);
  endtask : fchk

  task automatic wrap_up;
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    rd(uhi_pkg::ADDR_CFG, rv);
    chk(rv, 8'hFC);
    rd(8'h44, rv);
    chk(rv, 8'h00);
    wrd(uhi_pkg::ADDR_CFG, 8'hA9, rv);
    chk(rv, 8'hA9);
  endtask : t_reset

  task automatic t_filter;
    fchk(8'h00, T_IN, K_NAK, 3'h0, 8'h01);
    fchk(8'h00, T_IN, K_NAK, 3'h1, 8'h02);
    fchk(8'h00, T_OUT, K_NAK, 3'h2, 8'h04);
    fchk(8'h54, T_IN, K_NAK, 3'h0, 8'h00);
    fchk(8'h54, T_OUT, K_ACK, 3'h0, 8'h01);
    fchk(8'h54, T_IN, K_NAK, 3'h3, 8'h00);
    fchk(8'h54, T_IN, K_NYT, 3'h3, 8'h00);
    fchk(8'h54, T_OUT, K_NYT, 3'h7, 8'h04);
    fchk(8'h54, T_OUT, K_NAK, 3'h7, 8'h00);
    fchk(8'h54, T_SET, K_ACK, 3'h5, 8'h00);
  endtask : t_filter

  task automatic t_first;
    fchk(8'hFC, T_SET, K_ACK, 3'h0, 8'h01);
    fchk(8'hFC, T_IN, K_NAK, 3'h0, 8'h01);
    fchk(8'hFC, T_IN, K_NAK, 3'h0, 8'h00);
    fchk(8'hFC, T_OUT, K_NYT, 3'h2, 8'h04);
    fchk(8'hFC, T_IN, K_NAK, 3'h1, 8'h00);
  endtask : t_first

  task automatic t_level;
    host_high <= 1'b1;
    wr(uhi_pkg::ADDR_CFG, 8'h55);
    wr(uhi_pkg::ADDR_MASK, 8'h00);
    wr(uhi_pkg::ADDR_GEN, 8'h01);
    ev(T_IN, K_ACK, 3'h0);
    cyc(3);
    chk({7'h0, int_pin}, 8'h00);
    wr(uhi_pkg::ADDR_MASK, 8'h07);
    cyc(2);
    chk({7'h0, int_pin}, 8'h01);
    rd(uhi_pkg::ADDR_STAT, rv);
    chk(rv, 8'h01);
    cyc(2);
    chk({7'h0, int_pin}, 8'h00);
    wr(uhi_pkg::ADDR_GEN, 8'h00);
    ev(T_IN, K_ACK, 3'h0);
    cyc(3);
    chk({7'h0, int_pin}, 8'h00);
    wr(uhi_pkg::ADDR_GEN, 8'h01);
    cyc(2);
    chk({7'h0, int_pin}, 8'h01);
    rd(uhi_pkg::ADDR_STAT, rv);
    chk(rv, 8'h01);
  endtask : t_level

  task automatic t_pulse;
    for (int p = 0; p < 2; p++) begin
      host_high <= p[0];
      wr(uhi_pkg::ADDR_GEN, 8'h00);
      wr(uhi_pkg::ADDR_CFG, {7'h2B, p[0]});
      ev(T_IN, K_ACK, 3'h0);
      cyc(3);
      wr(uhi_pkg::ADDR_GEN, 8'h01);
      act(p[0], rv);
      chk(rv, 8'h00);
      e0 = host_edges;
      @(posedge sys_clk) hs_evt <= '{1'b1, T_IN, K_ACK, 3'h0};
      @(posedge sys_clk) hs_evt <= '{1'b1, T_OUT, K_ACK, 3'h1};
      @(posedge sys_clk) hs_evt.valid <= 1'b0;
      act(p[0], rv);
      chk(rv, 8'h03);
      chk(host_edges - e0, 8'h01);
      rd(uhi_pkg::ADDR_STAT, rv);
      chk(rv, 8'h05);
    end
  endtask : t_pulse

  task automatic t_busrst;
    wr(uhi_pkg::ADDR_CFG, 8'h03);
    @(posedge sys_clk) usb_bus_reset <= 1'b1;
    @(posedge sys_clk) usb_bus_reset <= 1'b0;
    rd(uhi_pkg::ADDR_CFG, rv);
    chk(rv, 8'hFF);
  endtask : t_busrst

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    rst_n           = 1'b0;
    hs_evt          = '0;
    usb_bus_reset   = 1'b0;
    reg_addr        = 8'h00;
    reg_wdata       = 8'h00;
    reg_wr          = 1'b0;
    reg_rd          = 1'b0;
    host_high       = 1'b0;
    num_errors      = 0;
    samples_checked = 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_filter();
    t_first();
    t_level();
    t_pulse();
    t_busrst();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    wrap_up();
  end
endmodule : uhi_irq_ctrl_test
